//--- rtl/pio_params.svh
// register map and field widths of the parallel port block
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH
`define PIO_ADDR_W       3
`define PIO_DATA_W       8
`define PIO_PORT_A_W     8
`define PIO_PORT_B_W     8
`define PIO_PORT_C_W     7
`define PIO_PORT_D_W     7
`define PIO_OFS_A_DATA   3'h0
`define PIO_OFS_B_DATA   3'h1
`define PIO_OFS_C_DATA   3'h2
`define PIO_OFS_D_DATA   3'h3
`define PIO_OFS_A_DIR    3'h4
`define PIO_OFS_B_DIR    3'h5
`define PIO_OFS_C_DIR    3'h6
`define PIO_DIR_RST      8'h00
`define PIO_RD_IDLE      8'h00
`endif

//--- rtl/pio_pkg.sv
// shared types of the parallel port block
`default_nettype none
package pio_pkg;
  `include "pio_params.svh"
  typedef logic [`PIO_ADDR_W-1:0] addr_t;
  typedef logic [`PIO_DATA_W-1:0] byte_t;
endpackage
`default_nettype wire

//--- rtl/pio_ports.sv
// parallel ports a to d: latches, direction, pin read-back
//
// The strobed register port was chosen for this implementation.
`default_nettype none
`include "pio_params.svh"

// Notes on behaviour
// - direction one drives pin, zero floats it
// - direction registers read/write, reset to inputs
// - reset leaves data latches untouched
// - port a read: latch if output, else pin
// - port b read: latch if output, else pin
// - port c read: latch if output, else pin
// - writes always update the data latch
// - input bit write leaves pin and read
// - port a has eight bidirectional pins
// - port b eight pins, shared with converter
// - port c seven pins, bits six to zero
// - port d seven input-only pins, never driven
// - port d read returns pin levels
module pio_ports (
  input  wire logic                        clk_i,
  input  wire logic                        srst_i,
  input  wire pio_pkg::addr_t              addr_i,
  input  wire pio_pkg::byte_t              wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output pio_pkg::byte_t                   rdata_o,
  input  wire logic [`PIO_PORT_A_W-1:0]    port_a_in_i,
  output logic      [`PIO_PORT_A_W-1:0]    port_a_out_o,
  output logic      [`PIO_PORT_A_W-1:0]    port_a_oe_o,
  input  wire logic [`PIO_PORT_B_W-1:0]    port_b_in_i,
  output logic      [`PIO_PORT_B_W-1:0]    port_b_out_o,
  output logic      [`PIO_PORT_B_W-1:0]    port_b_oe_o,
  input  wire logic [`PIO_PORT_C_W-1:0]    port_c_in_i,
  output logic      [`PIO_PORT_C_W-1:0]    port_c_out_o,
  output logic      [`PIO_PORT_C_W-1:0]    port_c_oe_o,
  input  wire logic [`PIO_PORT_D_W-1:0]    port_d_in_i
);
  import pio_pkg::*;

  logic [`PIO_PORT_A_W-1:0] port_a_data_latch_q;
  logic [`PIO_PORT_B_W-1:0] port_b_data_latch_q;
  logic [`PIO_PORT_C_W-1:0] port_c_data_latch_q;
  logic [`PIO_PORT_D_W-1:0] port_d_input_data_q;
  logic [`PIO_PORT_A_W-1:0] port_a_direction_q;
  logic [`PIO_PORT_B_W-1:0] port_b_direction_q;
  logic [`PIO_PORT_C_W-1:0] port_c_direction_q;
  logic [`PIO_PORT_A_W-1:0] pin_a_sync;
  logic [`PIO_PORT_B_W-1:0] pin_b_sync;
  logic [`PIO_PORT_C_W-1:0] pin_c_sync;
  logic [`PIO_PORT_D_W-1:0] pin_d_sync;
  byte_t                    rdata_q;
  byte_t                    rdata_d;

  function automatic byte_t mix(input byte_t latch, input byte_t dir, input byte_t pin);
    mix = (latch & dir) | (pin & ~dir);
  endfunction

  pio_sync #(.W(`PIO_PORT_A_W)) u_sync_a (
    .clk_i   (clk_i),
    .async_i (port_a_in_i),
    .sync_o  (pin_a_sync)
  );
  pio_sync #(.W(`PIO_PORT_B_W)) u_sync_b (
    .clk_i   (clk_i),
    .async_i (port_b_in_i),
    .sync_o  (pin_b_sync)
  );
  pio_sync #(.W(`PIO_PORT_C_W)) u_sync_c (
    .clk_i   (clk_i),
    .async_i (port_c_in_i),
    .sync_o  (pin_c_sync)
  );
  pio_sync #(.W(`PIO_PORT_D_W)) u_sync_d (
    .clk_i   (clk_i),
    .async_i (port_d_in_i),
    .sync_o  (pin_d_sync)
  );

  // one strobe qualified by one register index; the checks use it too
  function automatic logic hit(input logic strobe, input addr_t idx, input addr_t ofs);
    hit = strobe && (idx == ofs);
  endfunction

  wire wr_a_data = hit(wr_i, addr_i, `PIO_OFS_A_DATA);
  wire wr_b_data = hit(wr_i, addr_i, `PIO_OFS_B_DATA);
  wire wr_c_data = hit(wr_i, addr_i, `PIO_OFS_C_DATA);
  wire wr_d_data = hit(wr_i, addr_i, `PIO_OFS_D_DATA);
  wire wr_a_dir  = hit(wr_i, addr_i, `PIO_OFS_A_DIR);
  wire wr_b_dir  = hit(wr_i, addr_i, `PIO_OFS_B_DIR);
  wire wr_c_dir  = hit(wr_i, addr_i, `PIO_OFS_C_DIR);

  wire byte_t rd_a = mix(port_a_data_latch_q, port_a_direction_q, pin_a_sync);
  wire byte_t rd_b = mix(port_b_data_latch_q, port_b_direction_q, pin_b_sync);
  // port c read selection, bit 7 reads zero
  wire byte_t rd_c = mix({1'b0, port_c_data_latch_q}, {1'b0, port_c_direction_q},
                         {1'b0, pin_c_sync});
  wire byte_t rd_d = {1'b0, pin_d_sync};

  always_comb begin
    rdata_d = `PIO_RD_IDLE;
    if (rd_i) begin
      unique case (addr_i)
        `PIO_OFS_A_DATA: rdata_d = rd_a;
        `PIO_OFS_B_DATA: rdata_d = rd_b;
        `PIO_OFS_C_DATA: rdata_d = rd_c;
        `PIO_OFS_D_DATA: rdata_d = rd_d;
        `PIO_OFS_A_DIR:  rdata_d = port_a_direction_q;
        `PIO_OFS_B_DIR:  rdata_d = port_b_direction_q;
        `PIO_OFS_C_DIR:  rdata_d = {1'b0, port_c_direction_q};
        default:         rdata_d = `PIO_RD_IDLE;
      endcase
    end
  end

  // latches have no reset; write always stored
  always_ff @(posedge clk_i) begin
    if (wr_a_data) port_a_data_latch_q <= wdata_i;
    if (wr_b_data) port_b_data_latch_q <= wdata_i;
    if (wr_c_data) port_c_data_latch_q <= wdata_i[`PIO_PORT_C_W-1:0];
    if (wr_d_data) port_d_input_data_q <= wdata_i[`PIO_PORT_D_W-1:0];
  end

  // check helpers, set by the first write and never cleared, as reset
  // keeps the latches; before that write a latch holds no defined value
  logic latch_a_seen_q;
  logic latch_b_seen_q;
  logic latch_c_seen_q;
  logic latch_d_seen_q;

  always_ff @(posedge clk_i) begin
    if (wr_a_data) latch_a_seen_q <= 1'b1;
    if (wr_b_data) latch_b_seen_q <= 1'b1;
    if (wr_c_data) latch_c_seen_q <= 1'b1;
    if (wr_d_data) latch_d_seen_q <= 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      port_a_direction_q <= `PIO_DIR_RST;
      port_b_direction_q <= `PIO_DIR_RST;
      port_c_direction_q <= `PIO_PORT_C_W'(`PIO_DIR_RST);
      rdata_q            <= `PIO_RD_IDLE;
    end else begin
      if (wr_a_dir) port_a_direction_q <= wdata_i;
      if (wr_b_dir) port_b_direction_q <= wdata_i;
      if (wr_c_dir) port_c_direction_q <= wdata_i[`PIO_PORT_C_W-1:0];
      rdata_q <= rdata_d;
    end
  end

  // drivers follow direction; out carries latch whatever the enable
  assign port_a_out_o = port_a_data_latch_q;
  assign port_b_out_o = port_b_data_latch_q;
  assign port_c_out_o = port_c_data_latch_q;
  assign port_a_oe_o  = port_a_direction_q;
  assign port_b_oe_o  = port_b_direction_q;
  assign port_c_oe_o  = port_c_direction_q;
  assign rdata_o      = rdata_q;

  // port d has no driver: no output pins exist for it
  // left to software; latch write before direction is honoured

  a_dir_reset: assert property (@(posedge clk_i) srst_i |=>
    (port_a_oe_o == '0) && (port_b_oe_o == '0) && (port_c_oe_o == '0))
    else $error("direction not cleared by reset");

  a_dir_write: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_i && addr_i == `PIO_OFS_A_DIR) |=> port_a_oe_o == $past(wdata_i))
    else $error("port a enable does not follow direction write");

  a_latch_write: assert property (@(posedge clk_i)
    (wr_i && addr_i == `PIO_OFS_B_DATA) |=> port_b_out_o == $past(wdata_i))
    else $error("port b latch not written");

  a_latch_keep: assert property (@(posedge clk_i)
    (srst_i && !wr_i && latch_a_seen_q) |=> $stable(port_a_out_o))
    else $error("reset disturbed port a latch");

  a_read_mix_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (rd_i && addr_i == `PIO_OFS_A_DATA) |=>
    rdata_o == (($past(port_a_out_o) & $past(port_a_oe_o)) |
                ($past(pin_a_sync) & ~$past(port_a_oe_o))))
    else $error("port a read mix wrong");

  a_read_mix_b: assert property (@(posedge clk_i) disable iff (srst_i)
    (rd_i && addr_i == `PIO_OFS_B_DATA) |=>
    rdata_o == (($past(port_b_out_o) & $past(port_b_oe_o)) |
                ($past(pin_b_sync) & ~$past(port_b_oe_o))))
    else $error("port b read mix wrong");

  a_read_mix_c: assert property (@(posedge clk_i) disable iff (srst_i)
    (rd_i && addr_i == `PIO_OFS_C_DATA) |=> rdata_o[7] == 1'b0 &&
    rdata_o[6:0] == (($past(port_c_out_o) & $past(port_c_oe_o)) |
                     ($past(pin_c_sync) & ~$past(port_c_oe_o))))
    else $error("port c read mix wrong");

  a_input_write: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_i && addr_i == `PIO_OFS_A_DATA && port_a_oe_o == '0) |=> port_a_oe_o == '0)
    else $error("input write changed drive");

  a_pin_d_sync: assert property (@(posedge clk_i) disable iff (srst_i)
    (rd_i && addr_i == `PIO_OFS_D_DATA) |=> rdata_o == {1'b0, $past(port_d_in_i, 3)})
    else $error("port d read not three cycles of pin");

  a_idle_zero: assert property (@(posedge clk_i) disable iff (srst_i)
    !rd_i |=> rdata_o == `PIO_RD_IDLE)
    else $error("read data not idle");

  a_latch_keep_b: assert property (@(posedge clk_i)
    (srst_i && !wr_i && latch_b_seen_q) |=> $stable(port_b_out_o))
    else $error("reset disturbed port b latch");

  a_latch_keep_c: assert property (@(posedge clk_i)
    (srst_i && !wr_i && latch_c_seen_q) |=> $stable(port_c_out_o))
    else $error("reset disturbed port c latch");

  a_latch_keep_d: assert property (@(posedge clk_i)
    (srst_i && !wr_i && latch_d_seen_q) |=> $stable(port_d_input_data_q))
    else $error("reset disturbed port d latch");

  a_dir_write_b: assert property (@(posedge clk_i) disable iff (srst_i)
    hit(wr_i, addr_i, `PIO_OFS_B_DIR) |=> port_b_oe_o == $past(wdata_i))
    else $error("port b enable does not follow direction write");

  a_dir_write_c: assert property (@(posedge clk_i) disable iff (srst_i)
    hit(wr_i, addr_i, `PIO_OFS_C_DIR) |=> port_c_oe_o == $past(wdata_i[`PIO_PORT_C_W-1:0]))
    else $error("port c enable does not follow direction write");

  a_dir_hold_a: assert property (@(posedge clk_i)
    (!srst_i && !hit(wr_i, addr_i, `PIO_OFS_A_DIR)) |=> $stable(port_a_oe_o))
    else $error("port a direction changed without write");

  a_dir_hold_b: assert property (@(posedge clk_i)
    (!srst_i && !hit(wr_i, addr_i, `PIO_OFS_B_DIR)) |=> $stable(port_b_oe_o))
    else $error("port b direction changed without write");

  a_dir_hold_c: assert property (@(posedge clk_i)
    (!srst_i && !hit(wr_i, addr_i, `PIO_OFS_C_DIR)) |=> $stable(port_c_oe_o))
    else $error("port c direction changed without write");

  a_latch_write_a: assert property (@(posedge clk_i)
    hit(wr_i, addr_i, `PIO_OFS_A_DATA) |=> port_a_out_o == $past(wdata_i))
    else $error("port a latch not written");

  a_latch_write_c: assert property (@(posedge clk_i)
    hit(wr_i, addr_i, `PIO_OFS_C_DATA) |=> port_c_out_o == $past(wdata_i[`PIO_PORT_C_W-1:0]))
    else $error("port c latch not written");

  a_latch_write_d: assert property (@(posedge clk_i)
    hit(wr_i, addr_i, `PIO_OFS_D_DATA) |=>
    port_d_input_data_q == $past(wdata_i[`PIO_PORT_D_W-1:0]))
    else $error("port d latch not written");

  a_read_dir_a: assert property (@(posedge clk_i) disable iff (srst_i)
    hit(rd_i, addr_i, `PIO_OFS_A_DIR) |=> rdata_o == $past(port_a_oe_o))
    else $error("port a direction read wrong");

  a_read_dir_b: assert property (@(posedge clk_i) disable iff (srst_i)
    hit(rd_i, addr_i, `PIO_OFS_B_DIR) |=> rdata_o == $past(port_b_oe_o))
    else $error("port b direction read wrong");

  a_read_dir_c: assert property (@(posedge clk_i) disable iff (srst_i)
    hit(rd_i, addr_i, `PIO_OFS_C_DIR) |=> rdata_o == {1'b0, $past(port_c_oe_o)})
    else $error("port c direction read wrong");

  a_pin_a_sync: assert property (@(posedge clk_i) disable iff (srst_i)
    (hit(rd_i, addr_i, `PIO_OFS_A_DATA) && port_a_oe_o == '0) |=>
    rdata_o == $past(port_a_in_i, 3))
    else $error("port a read not three cycles of pin");

  a_pin_b_sync: assert property (@(posedge clk_i) disable iff (srst_i)
    (hit(rd_i, addr_i, `PIO_OFS_B_DATA) && port_b_oe_o == '0) |=>
    rdata_o == $past(port_b_in_i, 3))
    else $error("port b read not three cycles of pin");

  a_pin_c_sync: assert property (@(posedge clk_i) disable iff (srst_i)
    (hit(rd_i, addr_i, `PIO_OFS_C_DATA) && port_c_oe_o == '0) |=>
    rdata_o == {1'b0, $past(port_c_in_i, 3)})
    else $error("port c read not three cycles of pin");

  a_input_read: assert property (@(posedge clk_i) disable iff (srst_i)
    (hit(wr_i, addr_i, `PIO_OFS_A_DATA) && port_a_oe_o == '0) ##1
    (hit(rd_i, addr_i, `PIO_OFS_A_DATA) && port_a_oe_o == '0) |=>
    rdata_o == $past(pin_a_sync))
    else $error("input write leaked into port a read");

  c_read_a:  cover property (@(posedge clk_i) rd_i && addr_i == `PIO_OFS_A_DATA);
  c_dir_out: cover property (@(posedge clk_i) wr_i && addr_i == `PIO_OFS_C_DIR);
  c_read_d:  cover property (@(posedge clk_i) rd_i && addr_i == `PIO_OFS_D_DATA);
  c_read_c_mix: cover property (@(posedge clk_i)
    hit(rd_i, addr_i, `PIO_OFS_C_DATA) && port_c_oe_o != '0);
  c_reset_keep: cover property (@(posedge clk_i) srst_i && latch_a_seen_q);
endmodule // pio_ports
`default_nettype wire

//--- rtl/pio_sync.sv
// two-stage synchroniser for a group of pin levels
`default_nettype none
module pio_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // no reset: pin levels carry no meaning until sampled
  always_ff @(posedge clk_i) begin
    meta_q <= async_i;
    sync_q <= meta_q;
  end

  assign sync_o = sync_q;
endmodule // pio_sync
`default_nettype wire

//--- sim/pio_pin_model.sv
// pad model: each pad follows the port when driven, else the outside level
`default_nettype none
module pio_pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] ext_i,
  output logic      [W-1:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // enabled bits carry the latch, released bits the outside level
  assign pad_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule // pio_pin_model
`default_nettype wire

//--- sim/tb_pio_ports.sv
// self-checking bench of the parallel port block
`default_nettype none
module tb_pio_ports;
  timeunit 1ns;
  timeprecision 1ps;
  import pio_pkg::*;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
  logic       clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  addr_t      addr_i = '0;
  byte_t      wdata_i = '0;
  byte_t      rdata_o;
  logic [7:0] ext [3] = '{8'h00, 8'h00, 8'h00};
  logic [6:0] d_ext = 7'h00;
  wire  [7:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
  wire  [6:0] c_in, c_out, c_oe;
  int         n_errors = 0, num_checks = 0, cyc = 0, p;
  byte_t      lat [3] = '{8'hA5, 8'h5A, 8'h33};
  // port c value sets bit 1 as small-package setups need
  byte_t      dir [3] = '{8'hF0, 8'h0F, 8'h02};
  byte_t      pin [3] = '{8'h3C, 8'hC3, 8'h55};
  byte_t      msk [3] = '{8'hFF, 8'hFF, 8'h7F};
  always #2.5 clk_i = ~clk_i;
  pio_ports pio_ports_i (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .port_a_in_i(a_in), .port_a_out_o(a_out), .port_a_oe_o(a_oe),
    .port_b_in_i(b_in), .port_b_out_o(b_out), .port_b_oe_o(b_oe),
    .port_c_in_i(c_in), .port_c_out_o(c_out), .port_c_oe_o(c_oe),
    .port_d_in_i(d_ext));
  pio_pin_model #(.W(8)) pio_pin_model_a_i (.out_i(a_out), .oe_i(a_oe), .ext_i(ext[0]),
    .pad_o(a_in));
  pio_pin_model #(.W(8)) pio_pin_model_b_i (.out_i(b_out), .oe_i(b_oe), .ext_i(ext[1]),
    .pad_o(b_in));
  pio_pin_model #(.W(7)) pio_pin_model_c_i (.out_i(c_out), .oe_i(c_oe),
    .ext_i(ext[2][6:0]), .pad_o(c_in));
  task automatic wr(input addr_t a, input byte_t d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input addr_t a, input byte_t e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 `CHK(rdata_o, e)
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // bound on a hung run, far above the ~85 cycles the tests need
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    for (p = 0; p < 3; p++) rd(addr_t'(p + 4), 8'h00);
    `CHK({a_oe, b_oe, c_oe}, 23'h0)
    $display("test reset_state done");
    for (p = 0; p < 3; p++) begin
      @(posedge clk_i);
      ext[p] <= pin[p];
      wr(addr_t'(p), lat[p]);
      repeat (4) @(posedge clk_i);
      rd(addr_t'(p), pin[p] & msk[p]);
      wr(addr_t'(p + 4), dir[p]);
      rd(addr_t'(p + 4), dir[p] & msk[p]);
      rd(addr_t'(p), ((lat[p] & dir[p]) | (pin[p] & ~dir[p])) & msk[p]);
    end
    `CHK({a_out, b_out, c_out}, {lat[0], lat[1], lat[2][6:0]})
    `CHK({a_oe, b_oe, c_oe}, {dir[0], dir[1], dir[2][6:0]})
    `CHK(a_in, (lat[0] & dir[0]) | (pin[0] & ~dir[0]))
    $display("test mixed_direction done");
    @(posedge clk_i);
    d_ext <= 7'h55;
    wr(3'h3, 8'h2A);
    repeat (4) @(posedge clk_i);
    rd(3'h3, 8'h55);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    rd(3'h4, dir[0]);
    $display("test input_port done");
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK({a_out, b_out, c_out}, {lat[0], lat[1], lat[2][6:0]})
    `CHK({a_oe, b_oe, c_oe}, 23'h0)
    rd(3'h0, pin[0]);
    $display("test second_reset done");
    print_verdict();
  end
endmodule // tb_pio_ports
`default_nettype wire
